//--- include/cos_params.svh
`ifndef COS_PARAMS_SVH
`define COS_PARAMS_SVH

// Condition word layout
`define COS_COND_W        16
`define COS_COND_RESET    16'h0000
`define COS_BIT_CAL       0
`define COS_BIT_SETTLE    1
`define COS_BIT_RANGE     2
`define COS_BIT_MEASURE   4
`define COS_BIT_ARM       6
`define COS_BIT_AZERO     7
`define COS_BIT_TEST      8
`define COS_BIT_ABORT     9
// Bits that may ever read as one
`define COS_COND_USED     16'h03d7

// Time interval results are in picoseconds
`define COS_TINT_W        32
`define COS_NOM_DELAY_NS  1.8
`define COS_NOM_DELAY_PS  32'h0000_0708
`define COS_COIN_TOL_PS   32'h0000_0064

`endif

//--- include/cos_pkg.sv
`default_nettype none

package cos_pkg;

  // Activity start and end strobes from the instrument sequencer
  typedef struct packed {
    logic cal_start;
    logic cal_done;
    logic func_change;
    logic range_change;
    logic settled;
    logic autorange_start;
    logic range_found;
    logic start_measure_command;
    logic meas_done;
    logic arm_wait;
    logic arm_received;
    logic azero_start;
    logic azero_done;
    logic test_start;
    logic test_done;
    logic abort_start;
    logic abort_done;
  } cos_act_t;

  // Gate setup of the current measurement
  typedef struct packed {
    logic        ext_gate;
    logic [31:0] event_count;
    logic [31:0] aperture_events;
  } cos_gate_t;

  // Result path classification
  typedef enum logic [1:0] {
    COS_PATH_IDLE,
    COS_PATH_SHOT,
    COS_PATH_GATED
  } cos_path_t;

endpackage

`default_nettype wire

//--- rtl/cos_coin_cmp.sv
`timescale 1ns/10ps
`default_nettype none
`include "cos_params.svh"

module cos_coin_cmp #(
  parameter int TINT_W = `COS_TINT_W
) (
  // Compare operands
  input  wire logic [TINT_W-1:0] tint_in,
  input  wire logic [TINT_W-1:0] cal_delay_in,
  input  wire logic [TINT_W-1:0] tol_in,
  // Result
  output logic                   coin_out
);

  // Distance between two unsigned values
  function automatic logic [TINT_W-1:0] abs_diff(input logic [TINT_W-1:0] a,
                                                 input logic [TINT_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Result lies within the tolerance band around the calibrated delay
  assign coin_out = (abs_diff(tint_in, cal_delay_in) <= tol_in); // R1

endmodule
`default_nettype wire

//--- rtl/cos_status.sv
// What this block does
// (R1) Flag results near calibrated front-end delay
// (R2) Single shot: substitute delay, no error
// (R3) Continuous/array: test each, substitute, no error
// (R4) Gated: test at gate end, error
// (R5) Gated coincidence error goes to status
// (R6) Query returns live word, zero after reset
// (R7) Bit 0 high during operation_a
// (R8) Bit 1 set on change until settled
// (R9) Bit 2 high during auto-ranging
// (R10) Bit 4 from start until done/abort
// (R11) Bit 6 high while awaiting arm
// (R12) Bit 7 high during auto-zero
// (R13) Bit 8 high during self-test
// (R14) Bit 9 high while aborting
// (R15) Unused bits zero; reads change nothing
`timescale 1ns/10ps
`default_nettype none
`include "cos_params.svh"

module cos_status
  import cos_pkg::*;
#(
  parameter int                  TINT_W    = `COS_TINT_W,
  parameter logic [TINT_W-1:0]   COIN_TOL  = `COS_COIN_TOL_PS
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Activity strobes
  input  wire cos_act_t              act_in,
  // Condition query
  input  wire logic                  query_in,
  output logic                       cond_valid_out,
  output logic [`COS_COND_W-1:0]     cond_word_out,
  // Measurement results
  input  wire cos_gate_t             gate_in,
  input  wire logic                  tint_valid_in,
  input  wire logic                  gate_end_in,
  input  wire logic [TINT_W-1:0]     tint_in,
  input  wire logic [TINT_W-1:0]     cal_delay_in,
  output logic                       res_valid_out,
  output logic [TINT_W-1:0]          res_out,
  output logic                       coin_flag_out,
  output logic                       coin_error_out
);

  // Condition, query and result state
  logic [`COS_COND_W-1:0] cond_ff;
  logic [`COS_COND_W-1:0] nxt_cond;
  logic                   coin;
  logic                   gated;
  cos_path_t              path;
  logic                   cond_valid_ff;
  logic [`COS_COND_W-1:0] cond_word_ff;
  logic                   res_valid_ff;
  logic [TINT_W-1:0]      res_ff;
  logic                   coin_flag_ff;
  logic                   coin_error_ff;

  // Set has priority over clear so a start never gets lost
  function automatic logic set_clr(input logic cur, input logic set, input logic clr);
    set_clr = set | (cur & ~clr);
  endfunction

  // A measurement is gated if an external gate or multi-event window is used
  function automatic logic is_gated(input cos_gate_t g);
    is_gated = g.ext_gate | (g.event_count > 32'h1) | (g.aperture_events > 32'h1);
  endfunction

  // Next condition word from activity strobes
  always_comb begin
    nxt_cond = `COS_COND_RESET; // R15
    nxt_cond[`COS_BIT_CAL] = set_clr(cond_ff[`COS_BIT_CAL],
                                     act_in.cal_start, act_in.cal_done); // R7
    nxt_cond[`COS_BIT_SETTLE] = set_clr(cond_ff[`COS_BIT_SETTLE],
                                        act_in.func_change | act_in.range_change,
                                        act_in.settled); // R8
    nxt_cond[`COS_BIT_RANGE] = set_clr(cond_ff[`COS_BIT_RANGE],
                                       act_in.autorange_start, act_in.range_found); // R9
    nxt_cond[`COS_BIT_MEASURE] = set_clr(cond_ff[`COS_BIT_MEASURE],
                                         act_in.start_measure_command,
                                         act_in.meas_done | act_in.abort_done); // R10
    nxt_cond[`COS_BIT_ARM] = set_clr(cond_ff[`COS_BIT_ARM],
                                     act_in.arm_wait, act_in.arm_received); // R11
    nxt_cond[`COS_BIT_AZERO] = set_clr(cond_ff[`COS_BIT_AZERO],
                                       act_in.azero_start, act_in.azero_done); // R12
    nxt_cond[`COS_BIT_TEST] = set_clr(cond_ff[`COS_BIT_TEST],
                                      act_in.test_start, act_in.test_done); // R13
    nxt_cond[`COS_BIT_ABORT] = set_clr(cond_ff[`COS_BIT_ABORT],
                                       act_in.abort_start, act_in.abort_done); // R14
  end

  // Live condition word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_ff <= `COS_COND_RESET; // R6
    end else begin
      cond_ff <= nxt_cond;
    end
  end

  // Query answer, a snapshot that leaves the live word untouched
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_valid_ff <= 1'b0;
      cond_word_ff  <= `COS_COND_RESET;
    end else begin
      cond_valid_ff <= query_in;
      if (query_in) begin
        cond_word_ff <= cond_ff & `COS_COND_USED; // R6 R15
      end
    end
  end

  // Registered query outputs
  assign cond_valid_out = cond_valid_ff;
  assign cond_word_out  = cond_word_ff;

  // Coincidence comparator
  cos_coin_cmp #(
    .TINT_W       (TINT_W)
  ) u_coin (
    .tint_in      (tint_in),
    .cal_delay_in (cal_delay_in),
    .tol_in       (COIN_TOL),
    .coin_out     (coin)
  );

  assign gated = is_gated(gate_in);

  // Classify the result now offered
  always_comb begin
    if (!tint_valid_in) begin
      path = COS_PATH_IDLE;
    end else if (gated) begin
      path = COS_PATH_GATED;
    end else begin
      path = COS_PATH_SHOT;
    end
  end

  // Result and coincidence handling
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_valid_ff  <= 1'b0;
      res_ff        <= '0;
      coin_flag_ff  <= 1'b0;
      coin_error_ff <= 1'b0;
    end else begin
      res_valid_ff  <= 1'b0;
      coin_error_ff <= 1'b0;
      case (path)
        COS_PATH_SHOT: begin
          res_valid_ff <= 1'b1;
          coin_flag_ff <= coin; // R1
          res_ff       <= coin ? cal_delay_in : tint_in; // R2 R3
        end
        COS_PATH_GATED: begin
          if (gate_end_in) begin
            res_valid_ff  <= 1'b1;
            res_ff        <= tint_in; // R4
            coin_flag_ff  <= coin; // R1
            coin_error_ff <= coin; // R4 R5
          end
        end
        COS_PATH_IDLE: begin
          res_valid_ff <= 1'b0;
        end
        default: begin
          res_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  // Registered result outputs
  assign res_valid_out  = res_valid_ff;
  assign res_out        = res_ff;
  assign coin_flag_out  = coin_flag_ff;
  assign coin_error_out = coin_error_ff;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Condition bits follow their set and clear pulses
  a_cal_bit_set: assert property (act_in.cal_start // R7
                                  |=> cond_ff[`COS_BIT_CAL])
    else $error("calibrating bit not set");
  a_cal_bit_clr: assert property (act_in.cal_done && !act_in.cal_start // R7
                                  |=> !cond_ff[`COS_BIT_CAL])
    else $error("calibrating bit not cleared");
  a_settle_set: assert property (act_in.func_change || act_in.range_change // R8
                                 |=> cond_ff[`COS_BIT_SETTLE])
    else $error("settling bit not set");
  a_settle_bit: assert property ((act_in.func_change || act_in.range_change) // R8
                                 ##1 (!act_in.settled)[*2]
                                 |-> cond_ff[`COS_BIT_SETTLE])
    else $error("settling bit dropped early");
  a_settle_clr: assert property (act_in.settled && !act_in.func_change // R8
                                 && !act_in.range_change
                                 |=> !cond_ff[`COS_BIT_SETTLE])
    else $error("settling bit not cleared");
  a_range_set: assert property (act_in.autorange_start // R9
                                |=> cond_ff[`COS_BIT_RANGE])
    else $error("ranging bit not set");
  a_range_bit: assert property (act_in.range_found && !act_in.autorange_start // R9
                                |=> !cond_ff[`COS_BIT_RANGE])
    else $error("ranging bit not cleared");
  a_meas_bit_set: assert property (act_in.start_measure_command // R10
                                   |=> cond_ff[`COS_BIT_MEASURE])
    else $error("measuring bit not set");
  a_meas_bit_clr: assert property ((act_in.meas_done || act_in.abort_done) // R10
                                   && !act_in.start_measure_command
                                   |=> !cond_ff[`COS_BIT_MEASURE])
    else $error("measuring bit not cleared");
  a_arm_set: assert property (act_in.arm_wait // R11
                              |=> cond_ff[`COS_BIT_ARM])
    else $error("arming bit not set");
  a_arm_bit: assert property (act_in.arm_wait ##1 !act_in.arm_received // R11
                              |=> cond_ff[`COS_BIT_ARM])
    else $error("arming bit lost");
  a_arm_clr: assert property (act_in.arm_received && !act_in.arm_wait // R11
                              |=> !cond_ff[`COS_BIT_ARM])
    else $error("arming bit not cleared");
  a_azero_set: assert property (act_in.azero_start // R12
                                |=> cond_ff[`COS_BIT_AZERO])
    else $error("auto-zero bit not set");
  a_azero_bit: assert property (act_in.azero_done && !act_in.azero_start // R12
                                |=> !cond_ff[`COS_BIT_AZERO])
    else $error("auto-zero bit not cleared");
  a_test_bit: assert property (act_in.test_start // R13
                               |=> cond_ff[`COS_BIT_TEST])
    else $error("testing bit not set");
  a_test_clr: assert property (act_in.test_done && !act_in.test_start // R13
                               |=> !cond_ff[`COS_BIT_TEST])
    else $error("testing bit not cleared");
  a_abort_set: assert property (act_in.abort_start // R14
                                |=> cond_ff[`COS_BIT_ABORT])
    else $error("aborting bit not set");
  a_abort_bit: assert property (act_in.abort_start ##1 act_in.abort_done // R14
                                && !act_in.abort_start
                                |=> !cond_ff[`COS_BIT_ABORT])
    else $error("aborting bit not cleared");

  // Query answers a snapshot and never disturbs the word
  a_unused_zero: assert property ((cond_ff & ~`COS_COND_USED) == 16'h0000) // R15
    else $error("unused condition bit set");
  a_query_value: assert property (query_in // R6 R15
                                  |=> cond_valid_out
                                  && cond_word_out == $past(cond_ff)
                                  && cond_ff == $past(nxt_cond))
    else $error("query answer wrong");
  a_query_quiet: assert property (!query_in // R15
                                  |=> !cond_valid_out && $stable(cond_word_out))
    else $error("query answer without query");

  // Result path and coincidence handling
  a_shot_subst: assert property (tint_valid_in && !gated && coin // R2 R3
                                 |=> res_valid_out && res_out == $past(cal_delay_in)
                                 && !coin_error_out)
    else $error("single shot substitution wrong");
  a_shot_plain: assert property (tint_valid_in && !gated && !coin // R2 R3
                                 |=> res_valid_out && res_out == $past(tint_in)
                                 && !coin_flag_out)
    else $error("single shot result altered");
  a_shot_valid: assert property (tint_valid_in && !gated // R3
                                 |=> res_valid_out && !coin_error_out)
    else $error("single shot result lost");
  a_gated_error: assert property (tint_valid_in && gated && gate_end_in && coin // R4 R5
                                  |=> coin_error_out && res_out == $past(tint_in))
    else $error("gated coincidence error missing");
  a_gated_plain: assert property (tint_valid_in && gated && gate_end_in && !coin // R4
                                  |=> res_valid_out && !coin_error_out
                                  && res_out == $past(tint_in))
    else $error("gated result wrong");
  a_gated_ignore: assert property (tint_valid_in && gated && !gate_end_in // R4
                                   |=> !res_valid_out)
    else $error("gated result taken before gate end");
  a_no_stray_err: assert property (!(tint_valid_in && gated && gate_end_in) // R4
                                   |=> !coin_error_out)
    else $error("coincidence error without gate end");
  a_flag_follow: assert property (tint_valid_in && (!gated || gate_end_in) // R1
                                  |=> coin_flag_out == $past(coin))
    else $error("coincidence flag wrong");
  a_result_hold: assert property (!(tint_valid_in && (!gated || gate_end_in)) // R4
                                  |=> !res_valid_out && $stable(res_out)
                                  && $stable(coin_flag_out))
    else $error("result changed without a taken result");
  a_err_needs_coin: assert property (coin_error_out // R4 R5
                                     |-> coin_flag_out && res_valid_out)
    else $error("coincidence error without flagged result");

  // Main scenarios
  c_query: cover property (query_in ##1 cond_valid_out && cond_word_out != 16'h0000);
  c_shot_coin: cover property (tint_valid_in && !gated && coin);
  c_gated_coin: cover property (tint_valid_in && gated && gate_end_in && coin);
  c_abort_meas: cover property (cond_ff[`COS_BIT_MEASURE] && act_in.abort_done);
  c_settle_done: cover property (cond_ff[`COS_BIT_SETTLE] && act_in.settled);

endmodule
`default_nettype wire

//--- bench/test_counter_operation_status.sv
`timescale 1ns/10ps
`default_nettype none
`include "cos_params.svh"

module test_counter_operation_status
  import cos_pkg::*;
;
  logic                    clk_in, rst_in, query_in, tint_valid_in, gate_end_in;
  cos_act_t                act_in;
  cos_gate_t               gate_in;
  logic [`COS_TINT_W-1:0]  tint_in, cal_delay_in, res_out, m_res;
  logic                    cond_valid_out, res_valid_out, coin_flag_out, coin_error_out, m_flag;
  logic [`COS_COND_W-1:0]  cond_word_out, m_word, m_snap;
  int                      fails, check_count, cycles;
  int                      offs[5] = '{-101, -100, 0, 100, 101};

  cos_status u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .act_in(act_in), .query_in(query_in),
    .cond_valid_out(cond_valid_out), .cond_word_out(cond_word_out), .gate_in(gate_in),
    .tint_valid_in(tint_valid_in), .gate_end_in(gate_end_in), .tint_in(tint_in),
    .cal_delay_in(cal_delay_in), .res_valid_out(res_valid_out), .res_out(res_out),
    .coin_flag_out(coin_flag_out), .coin_error_out(coin_error_out)
  );

  // Free running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reset with model cleared; outputs other than res_out must read zero while held
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("rst_word", cond_word_out, 0);
    chk("rst_res", {res_valid_out, coin_flag_out, coin_error_out, cond_valid_out}, 0);
    rst_in = 1'b0;
    m_word = '0;
    m_snap = '0;
    m_res = '0;
    m_flag = 1'b0;
  endtask

  // One cycle of stimulus, model update and full output compare
  task automatic cyc(input cos_act_t a, input logic q, input logic tv, input logic ge,
                     input logic [31:0] t);
    logic                   gated, coin, take, err;
    logic [31:0]            diff;
    logic [`COS_COND_W-1:0] set_m, clr_m;
    act_in = a;
    query_in = q;
    tint_valid_in = tv;
    gate_end_in = ge;
    tint_in = t;
    gated = gate_in.ext_gate | (gate_in.event_count > 1) | (gate_in.aperture_events > 1);
    diff = (t >= cal_delay_in) ? t - cal_delay_in : cal_delay_in - t;
    coin = (diff <= `COS_COIN_TOL_PS);
    take = tv & (!gated | ge);
    err = take & coin & gated;
    set_m = {6'h00, a.abort_start, a.test_start, a.azero_start, a.arm_wait, 1'b0,
             a.start_measure_command, 1'b0, a.autorange_start, a.func_change | a.range_change,
             a.cal_start};
    clr_m = {6'h00, a.abort_done, a.test_done, a.azero_done, a.arm_received, 1'b0,
             a.meas_done | a.abort_done, 1'b0, a.range_found, a.settled, a.cal_done};
    if (q) m_snap = m_word;
    if (take) begin
      m_res = (coin & !gated) ? cal_delay_in : t;
      m_flag = coin;
    end
    @(posedge clk_in);
    m_word = (m_word & ~clr_m) | set_m;
    @(negedge clk_in);
    chk("cond_valid", cond_valid_out, q);
    chk("cond_word", cond_word_out, m_snap);
    chk("res_valid", res_valid_out, take);
    chk("res", res_out, m_res);
    chk("coin_flag", coin_flag_out, m_flag);
    chk("coin_error", coin_error_out, err);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    cos_act_t a;
    fails = 0;
    check_count = 0;
    act_in = '0;
    query_in = 1'b0;
    tint_valid_in = 1'b0;
    gate_end_in = 1'b0;
    tint_in = '0;
    cal_delay_in = 32'h0000_0708;
    gate_in = '0;
    void'($urandom(46992));
    do_reset();
    // Tolerance edges, non gated then gated with and without gate end
    for (int g = 0; g < 3; g++) begin
      gate_in.ext_gate = (g != 0);
      foreach (offs[i]) cyc('0, 1'b1, 1'b1, g == 1, 32'(32'sh708 + offs[i]));
    end
    gate_in = '0;
    // Sparse random activity, queries and results, with a reset mid-run
    for (int n = 0; n < 1500; n++) begin
      if (n == 700) do_reset();
      gate_in.ext_gate = ($urandom % 4 == 0);
      gate_in.event_count = 32'($urandom % 3);
      gate_in.aperture_events = 32'($urandom % 3);
      if (n % 50 == 0) cal_delay_in = 32'h0000_0708 + 32'($urandom % 64);
      a = cos_act_t'(17'($urandom & $urandom & $urandom));
      cyc(a, 1'($urandom), 1'($urandom), 1'($urandom),
          cal_delay_in + 32'($urandom % 401) - 32'd200);
    end
    results();
  end
endmodule
`default_nettype wire
